// [verilog/nfcmc_pkg.sv]
/*
 * Package for the front-end mode control block: register offsets, field
 * positions, reset values and timing constants.
 * Assumes a single 100 MHz core clock and a plain register port.
 */
package nfcmc_pkg;

  // Register offsets (byte index on the plain port)
  localparam logic [7:0] ADDR_IO_CFG1   = 8'h00;
  localparam logic [7:0] ADDR_IO_CFG2   = 8'h01;
  localparam logic [7:0] ADDR_OP_CTRL   = 8'h02;
  localparam logic [7:0] ADDR_MODE_DEF  = 8'h03;
  localparam logic [7:0] ADDR_RX_CFG    = 8'h04;
  localparam logic [7:0] ADDR_TX_DRV    = 8'h05;
  localparam logic [7:0] ADDR_LM_CFG    = 8'h06;
  localparam logic [7:0] ADDR_LM_IMP    = 8'h07;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_MEM_DATA  = 8'h09;

  // Operation control bits
  localparam int OP_EN_BIT   = 7;
  localparam int OP_RXEN_BIT = 6;
  localparam int OP_RXCHN_BIT = 5;
  localparam int OP_RXMAN_BIT = 4;
  localparam int OP_TXEN_BIT = 3;
  localparam int OP_WU_BIT   = 2;

  // IO configuration 1 / 2 bits
  localparam int IO1_SINGLE_BIT = 7;
  localparam int IO1_OUT2_BIT   = 6;
  localparam int IO2_SLOWUP_BIT = 7;

  // Mode definition / receiver config bits
  localparam int MODE_AM_BIT    = 2;
  localparam int RX_CHSEL_BIT   = 0;
  localparam int RX_AMDSEL_BIT  = 1;

  // Load modulation config bits
  localparam int LM_DRI_BIT     = 0;
  localparam int LM_EXT_BIT     = 1;
  localparam int LM_POL_BIT     = 2;

  // Status bits
  localparam int ST_READY_BIT   = 0;
  localparam int ST_WAKE_BIT    = 1;
  localparam int ST_OSC_BIT     = 2;

  // Reset values; zero driver field selects minimum resistance
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_TX_DRV = 8'h00;

  // Segments per driver
  localparam int DRV_SEGS = 8;

  // Oscillator settle time and cycle count
  localparam int OSC_SETTLE_US  = 10;
  localparam int CLK_MHZ        = 100;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;

  // Wake-up measurement period default, in core cycles
  localparam int WAKE_PERIOD_CYC = 1000;

endpackage : nfcmc_pkg

// [verilog/nfcmc_top.sv]
/*
 * Mode and transmitter/receiver control of an NFC front end.
 * Assumes a host writing registers over a plain synchronous port, an
 * oscillator-good level, a wake measurement result and a modulation bit.
 */
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns

// What this block does
// - Reset enters power-down with every register at its default.
// - All operation bits zero: power-down, config ok, memory refused.
// - Enable bit seven gives ready mode, oscillator, regulators, memory access.
// - Ready mode raises interrupt once oscillator is stable.
// - Receiver and transmitter have independent enable bits.
// - Wake bit alone enters wake-up mode with periodic measurements.
// - Wake-up mode interrupts when measurement differs from reference.
// - Single driver bit uses one driver; select bit picks which.
// - Eight weighted segments; four-bit resistance field, default minimum.
// - Mode bit picks AM or OOK; OOK stops carrier, AM uses supply.
// - Four-bit AM depth field in driver register.
// - Internal and external load modulation selectable, both allowed.
// - Idle and modulated impedance fields; swapping inverts polarity.
// - External gate carries modulation signal, inverted by polarity bit.
// - Receiver on when enable set; auto channel unless manual.
// - Channel select picks AM/I at 0, PM/Q at 1 when manual.
// - Receiver bit picks peak detector or synchronous mixer demodulator.
module nfcmc_top (
  input  wire logic       core_clk,        // 100 MHz clock
  input  wire logic       rst_b,           // Async reset, active low
  input  wire logic       clk_en,          // Freezes all state when low
  input  wire logic [7:0] reg_addr,        // Register address
  input  wire logic [7:0] reg_wdata,       // Write data
  input  wire logic       reg_wr,          // Write strobe
  input  wire logic       reg_rd,          // Read strobe
  output logic      [7:0] reg_rdata,       // Read data, cycle after strobe
  input  wire logic       osc_stable,      // Oscillator amplitude/freq good
  input  wire logic       wake_differs,    // Measurement differs from ref
  input  wire logic       mod_signal,      // Digital modulation signal
  input  wire logic       tx_bit,          // Modulated state of transmitter
  output logic            irq,             // Interrupt request, level
  output logic            osc_enable,      // Crystal oscillator enable
  output logic            reg_enable,      // Regulators enable
  output logic            antenna_tuning,  // Tuning outputs enable
  output logic            rc_osc_enable,   // Low-power RC oscillator
  output logic            wake_measure,    // Wake-up measurement pulse
  output logic            rx_on,           // Receiver powered
  output logic            rx_chan_auto,    // Automatic channel selection
  output logic            rx_chan_pm,      // Manual channel is PM/Q
  output logic            rx_use_mixer,    // Mixer demodulator selected
  output logic            antenna_output_one, // Driver one active
  output logic            antenna_output_two, // Driver two active
  output logic      [7:0] drv_segments,    // Segments turned on
  output logic            drv_from_am,     // Drivers run from AM supply
  output logic      [3:0] am_depth_field,  // AM modulation depth
  output logic            external_modulation_gate, // External MOS gate
  output logic            mem_access_ok,   // Memory/FIFO accessible
  output logic            mem_refused      // Pulse on refused memory access
);

  typedef struct packed {
    logic [7:0]  io1, io2, op, mode, rxc, txd, lmc, lmi;
    logic [7:0]  rdata;
    logic        irq_pend;
    logic        osc_seen;
    logic [15:0] settle_cnt;
    logic [15:0] wake_cnt;
    logic        wake_pulse;
    logic        refused;
    logic        gate;
    logic [7:0]  segs;
  } nfcmc_state_s;

  nfcmc_state_s st_reg, st_next;

  // Ready when enable set; wake only when wake bit is the lone bit
  function automatic logic is_ready(input logic [7:0] op);
    is_ready = op[nfcmc_pkg::OP_EN_BIT];
  endfunction

  function automatic logic is_wake(input logic [7:0] op);
    is_wake = (op == (8'h01 << nfcmc_pkg::OP_WU_BIT));
  endfunction

  // Thermometer of segments from a four-bit resistance code: 0 => all on
  function automatic logic [7:0] seg_map(input logic [3:0] res);
    logic [7:0] m;
    m = 8'hff >> res[2:0];
    seg_map = res[3] ? 8'h00 : m;
  endfunction

  logic ready, wake, tx_en, single, out2, mod_am, drv_lm;
  logic [3:0] idle_res, mod_res;

  // Current mode: decides refusals, status and the timers
  always_comb begin
    ready    = is_ready(st_reg.op);
    wake     = is_wake(st_reg.op);
  end

  always_comb begin
    st_next = st_reg;
    st_next.refused = 1'b0;
    st_next.wake_pulse = 1'b0;
    // Configuration writes accepted in every mode; memory needs ready
    if (reg_wr) begin
      case (reg_addr)
        nfcmc_pkg::ADDR_IO_CFG1:  st_next.io1 = reg_wdata;
        nfcmc_pkg::ADDR_IO_CFG2:  st_next.io2 = reg_wdata;
        nfcmc_pkg::ADDR_OP_CTRL:  st_next.op  = reg_wdata;
        nfcmc_pkg::ADDR_MODE_DEF: st_next.mode = reg_wdata;
        nfcmc_pkg::ADDR_RX_CFG:   st_next.rxc = reg_wdata;
        nfcmc_pkg::ADDR_TX_DRV:   st_next.txd = reg_wdata;
        nfcmc_pkg::ADDR_LM_CFG:   st_next.lmc = reg_wdata;
        nfcmc_pkg::ADDR_LM_IMP:   st_next.lmi = reg_wdata;
        nfcmc_pkg::ADDR_MEM_DATA: st_next.refused = ~ready;
        default: ;
      endcase
    end
    // Driver controls except the TX resistance field follow the value being
    // written, so those outputs move one cycle after the write strobe, not two
    tx_en    = st_next.op[nfcmc_pkg::OP_TXEN_BIT] & is_ready(st_next.op);
    single   = st_next.io1[nfcmc_pkg::IO1_SINGLE_BIT];
    out2     = st_next.io1[nfcmc_pkg::IO1_OUT2_BIT];
    mod_am   = st_next.mode[nfcmc_pkg::MODE_AM_BIT];
    drv_lm   = st_next.lmc[nfcmc_pkg::LM_DRI_BIT];
    idle_res = st_next.lmi[3:0];
    mod_res  = st_next.lmi[7:4];
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        nfcmc_pkg::ADDR_IO_CFG1:  st_next.rdata = st_reg.io1;
        nfcmc_pkg::ADDR_IO_CFG2:  st_next.rdata = st_reg.io2;
        nfcmc_pkg::ADDR_OP_CTRL:  st_next.rdata = st_reg.op;
        nfcmc_pkg::ADDR_MODE_DEF: st_next.rdata = st_reg.mode;
        nfcmc_pkg::ADDR_RX_CFG:   st_next.rdata = st_reg.rxc;
        nfcmc_pkg::ADDR_TX_DRV:   st_next.rdata = st_reg.txd;
        nfcmc_pkg::ADDR_LM_CFG:   st_next.rdata = st_reg.lmc;
        nfcmc_pkg::ADDR_LM_IMP:   st_next.rdata = st_reg.lmi;
        nfcmc_pkg::ADDR_STATUS:   st_next.rdata = {5'h00,
            st_reg.osc_seen, wake, ready};
        nfcmc_pkg::ADDR_MEM_DATA: st_next.refused = ~ready;
        default: ;
      endcase
    end
    // Stable oscillator after ready entry raises one interrupt
    if (!ready) begin
      st_next.osc_seen = 1'b0;
      st_next.settle_cnt = 16'h0000;
    end else if (!st_reg.osc_seen && osc_stable) begin
      if (st_reg.settle_cnt ==
          16'(nfcmc_pkg::OSC_SETTLE_CYC - 1)) begin
        st_next.osc_seen = 1'b1;
        st_next.irq_pend = 1'b1;
      end else begin
        st_next.settle_cnt = st_reg.settle_cnt + 16'h0001;
      end
    end
    // Periodic measurement timer in wake-up mode
    if (wake) begin
      if (st_reg.wake_cnt ==
          16'(nfcmc_pkg::WAKE_PERIOD_CYC - 1)) begin
        st_next.wake_cnt = 16'h0000;
        st_next.wake_pulse = 1'b1;
      end else begin
        st_next.wake_cnt = st_reg.wake_cnt + 16'h0001;
      end
      if (wake_differs) begin
        st_next.irq_pend = 1'b1;
      end
    end else begin
      st_next.wake_cnt = 16'h0000;
    end
    // Status read clears interrupt; a new event in the same cycle wins
    if (reg_rd && reg_addr == nfcmc_pkg::ADDR_STATUS &&
        !(ready && !st_reg.osc_seen && osc_stable &&
          st_reg.settle_cnt == 16'(nfcmc_pkg::OSC_SETTLE_CYC - 1)) &&
        !(wake && wake_differs)) begin
      st_next.irq_pend = 1'b0;
    end
    // External gate follows modulation signal, optional inversion
    st_next.gate = st_next.lmc[nfcmc_pkg::LM_EXT_BIT] &
        (mod_signal ^ st_next.lmc[nfcmc_pkg::LM_POL_BIT]);
    // Segment pattern: TX resistance, or load-modulation impedances
    if (!tx_en) begin
      st_next.segs = 8'h00;
    end else if (drv_lm) begin
      st_next.segs = seg_map(tx_bit ? mod_res : idle_res);
    end else if (tx_bit && !mod_am) begin
      st_next.segs = 8'h00;
    end else begin
      st_next.segs = seg_map(st_reg.txd[3:0]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      osc_enable <= 1'b0;
      reg_enable <= 1'b0;
      antenna_tuning <= 1'b0;
      rc_osc_enable <= 1'b0;
      wake_measure <= 1'b0;
      rx_on <= 1'b0;
      rx_chan_auto <= 1'b0;
      rx_chan_pm <= 1'b0;
      rx_use_mixer <= 1'b0;
      antenna_output_one <= 1'b0;
      antenna_output_two <= 1'b0;
      drv_segments <= 8'h00;
      drv_from_am <= 1'b0;
      am_depth_field <= 4'h0;
      external_modulation_gate <= 1'b0;
      mem_access_ok <= 1'b0;
      mem_refused <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= st_next.rdata;
      irq <= st_next.irq_pend;
      osc_enable <= is_ready(st_next.op);
      reg_enable <= is_ready(st_next.op);
      antenna_tuning <= is_ready(st_next.op);
      mem_access_ok <= is_ready(st_next.op);
      rc_osc_enable <= is_wake(st_next.op);
      wake_measure <= st_next.wake_pulse;
      rx_on <= is_ready(st_next.op) &
          st_next.op[nfcmc_pkg::OP_RXEN_BIT];
      rx_chan_auto <= ~st_next.op[nfcmc_pkg::OP_RXCHN_BIT] &
          ~st_next.op[nfcmc_pkg::OP_RXMAN_BIT];
      rx_chan_pm <= st_next.rxc[nfcmc_pkg::RX_CHSEL_BIT];
      rx_use_mixer <= st_next.rxc[nfcmc_pkg::RX_AMDSEL_BIT];
      // Single driver: select bit picks output; else both drive
      antenna_output_one <= tx_en & ~(single & out2);
      antenna_output_two <= tx_en & ~(single & ~out2);
      drv_segments <= st_next.segs;
      drv_from_am <= tx_en & mod_am & tx_bit & ~drv_lm;
      am_depth_field <= st_next.txd[7:4];
      external_modulation_gate <= st_next.gate;
      mem_refused <= st_next.refused;
    end
  end

  // Assertions: outputs are registered from the next-state copy, so
  // they agree with st_reg after every edge, frozen or not

  // Enable write reaches ready mode at the next edge
  property p_ready_entry;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && reg_wr && reg_addr == nfcmc_pkg::ADDR_OP_CTRL &&
      reg_wdata[nfcmc_pkg::OP_EN_BIT] |=> osc_enable && mem_access_ok;
  endproperty
  a_ready_entry: assert property (p_ready_entry)
    else $error("ready mode not entered after enable write");

  // Ready mode brings oscillator, regulators and tuning together
  property p_ready_group;
    @(posedge core_clk) disable iff (!rst_b)
      mem_access_ok |-> osc_enable && reg_enable && antenna_tuning;
  endproperty
  a_ready_group: assert property (p_ready_group)
    else $error("ready mode resources not all enabled");

  // Memory access outside ready mode must be flagged
  property p_refuse;
    @(posedge core_clk) disable iff (!rst_b)
      clk_en && (reg_wr || reg_rd) &&
      reg_addr == nfcmc_pkg::ADDR_MEM_DATA && !mem_access_ok
      |=> mem_refused;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("memory access in power-down not refused");

  // Drivers stay silent in power-down whatever the enable bits say
  property p_tx_off;
    @(posedge core_clk) disable iff (!rst_b)
      !mem_access_ok |-> drv_segments == 8'h00 &&
        !antenna_output_one && !antenna_output_two;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("drivers active outside ready mode");

  // Receiver only powered in ready mode
  property p_rx_ready;
    @(posedge core_clk) disable iff (!rst_b)
      rx_on |-> mem_access_ok;
  endproperty
  a_rx_ready: assert property (p_rx_ready)
    else $error("receiver on outside ready mode");

  // Single-driver mode never drives both outputs
  property p_single;
    @(posedge core_clk) disable iff (!rst_b)
      st_reg.io1[nfcmc_pkg::IO1_SINGLE_BIT] |->
        !(antenna_output_one && antenna_output_two);
  endproperty
  a_single: assert property (p_single)
    else $error("both drivers active in single mode");

  // Modulation supply only used in AM mode
  property p_am_supply;
    @(posedge core_clk) disable iff (!rst_b)
      drv_from_am |-> st_reg.mode[nfcmc_pkg::MODE_AM_BIT];
  endproperty
  a_am_supply: assert property (p_am_supply)
    else $error("modulation supply used in OOK mode");

  // External gate idle unless external modulation is selected
  property p_gate_off;
    @(posedge core_clk) disable iff (!rst_b)
      !st_reg.lmc[nfcmc_pkg::LM_EXT_BIT] |-> !external_modulation_gate;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("external gate driven while not selected");

  // Wake-up mode runs on the RC oscillator, never the crystal
  property p_wake_rc;
    @(posedge core_clk) disable iff (!rst_b)
      rc_osc_enable |-> !osc_enable;
  endproperty
  a_wake_rc: assert property (p_wake_rc)
    else $error("crystal enabled in wake-up mode");

  // Measurements are only scheduled in wake-up mode
  property p_wake_pulse;
    @(posedge core_clk) disable iff (!rst_b)
      wake_measure |-> rc_osc_enable;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("measurement pulse outside wake-up mode");

  // Main scenarios
  c_irq: cover property (@(posedge core_clk) disable iff (!rst_b)
    irq);
  c_wake_measure: cover property (@(posedge core_clk) disable iff (!rst_b)
    wake_measure);
  c_refused: cover property (@(posedge core_clk) disable iff (!rst_b)
    mem_refused);
endmodule // nfcmc_top

// [bench/nfcmc_host.sv]
/*
 * Host model: drives the plain register port of the mode control block.
 * Assumes a 100 MHz core_clk and a bench that calls its tasks.
 */
`timescale 1ns/1ns
module nfcmc_host (
  input  wire logic       core_clk,  // Block clock
  output logic      [7:0] reg_addr,  // Register address
  output logic      [7:0] reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;  // Stale data must never look valid
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic init();
    wr(8'h04, 8'h10);
    wr(nfcmc_pkg::ADDR_IO_CFG1, 8'h00);
    wr(nfcmc_pkg::ADDR_IO_CFG2, 8'h00);
  endtask
endmodule // nfcmc_host

// [bench/nfcmc_top_tb.sv]
/*
 * Testbench of the front-end mode control block.
 * Assumes the host model for register traffic and a 100 MHz clock.
 */
`timescale 1ns/1ns
module nfcmc_top_tb;
  logic       core_clk, rst_b, clk_en, osc_stable, wake_differs;
  logic       mod_signal, tx_bit, reg_wr, reg_rd, irq, osc_enable;
  logic       reg_enable, antenna_tuning, rc_osc_enable, wake_measure;
  logic       rx_on, rx_chan_auto, rx_chan_pm, rx_use_mixer, drv_from_am;
  logic       antenna_output_one, antenna_output_two, mem_access_ok;
  logic       external_modulation_gate, mem_refused;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, drv_segments, d;
  logic [3:0] am_depth_field;
  int         fails, checks, k;

  nfcmc_top nfcmc_top_inst (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_stable(osc_stable),
    .wake_differs(wake_differs), .mod_signal(mod_signal),
    .tx_bit(tx_bit), .irq(irq), .osc_enable(osc_enable),
    .reg_enable(reg_enable), .antenna_tuning(antenna_tuning),
    .rc_osc_enable(rc_osc_enable), .wake_measure(wake_measure),
    .rx_on(rx_on), .rx_chan_auto(rx_chan_auto), .rx_chan_pm(rx_chan_pm),
    .rx_use_mixer(rx_use_mixer), .antenna_output_one(antenna_output_one),
    .antenna_output_two(antenna_output_two),
    .drv_segments(drv_segments), .drv_from_am(drv_from_am),
    .am_depth_field(am_depth_field),
    .external_modulation_gate(external_modulation_gate),
    .mem_access_ok(mem_access_ok), .mem_refused(mem_refused));

  nfcmc_host nfcmc_host_inst (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  always #5 core_clk = ~core_clk;

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic c8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic c1(input logic g, input logic e);
    c8({7'h0, g}, {7'h0, e});
  endtask

  // Bounded wait for irq (0) or the wake pulse (1), sampled after edges
  task automatic wait_for(input int which, input int n);
    logic s;
    s = 1'b0;
    for (int i = 0; i < n && s !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
      s = which ? wake_measure : irq;
    end
    c1(s, 1'b1);
    if (s !== 1'b1) complete_run();
  endtask

  initial begin
    #900_000;
    fails++;
    complete_run();
  end

  initial begin
    core_clk = 1'b0; rst_b = 1'b0; clk_en = 1'b1; osc_stable = 1'b0;
    wake_differs = 1'b0; mod_signal = 1'b0; tx_bit = 1'b0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    c1(osc_enable | mem_access_ok | rx_on | irq, 1'b0);
    nfcmc_host_inst.init();
    nfcmc_host_inst.rd(nfcmc_pkg::ADDR_MEM_DATA, d);
    c1(mem_refused, 1'b1);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_OP_CTRL, 8'h80);
    #1;
    c1(osc_enable & reg_enable & antenna_tuning & mem_access_ok, 1);
    nfcmc_host_inst.rd(nfcmc_pkg::ADDR_MEM_DATA, d);
    c1(mem_refused, 1'b0);
    osc_stable <= 1'b1;
    repeat (900) @(posedge core_clk);
    #1;
    c1(irq, 1'b0);
    wait_for(0, 200);
    nfcmc_host_inst.rd(nfcmc_pkg::ADDR_STATUS, d);
    c8(d, 8'h05);
    repeat (2) @(posedge core_clk);
    #1;
    c1(irq, 1'b0);
    // Driver: AM mode, depth a, minimum resistance, tx only
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_TX_DRV, 8'ha0);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_MODE_DEF, 8'h04);
    // Slow ramp set with transmitter off; hold shortened to bound the run
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_IO_CFG2, 8'h80);
    repeat (100) @(posedge core_clk);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_OP_CTRL, 8'h88);
    #1;
    c1(rx_on, 1'b0);
    c8(drv_segments, 8'hff);
    c8({4'h0, am_depth_field}, 8'h0a);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_IO_CFG2, 8'h00);
    nfcmc_host_inst.rd(nfcmc_pkg::ADDR_TX_DRV, d);
    c8(d, 8'ha0);
    tx_bit <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    c1(drv_from_am, 1'b1);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_MODE_DEF, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    c8(drv_segments, 8'h00);
    tx_bit <= 1'b0;
    for (k = 0; k < 3; k++) begin
      nfcmc_host_inst.wr(nfcmc_pkg::ADDR_IO_CFG1, {k[1] | k[0], k[1], 6'h0});
      #1;
      c1(antenna_output_one, k != 2);
      c1(antenna_output_two, k != 1);
    end
    for (k = 0; k < 8; k++) begin
      nfcmc_host_inst.wr(nfcmc_pkg::ADDR_RX_CFG, {6'h0, k[0], k[0]});
      nfcmc_host_inst.wr(nfcmc_pkg::ADDR_OP_CTRL, {2'b11, k[2:1], 4'h0});
      #1;
      c1(rx_on, 1'b1);
      c1(rx_chan_auto, !k[2] && !k[1]);
      if (k[2] || k[1]) c1(rx_chan_pm, k[0]);
      c1(rx_use_mixer, k[0]);
    end
    // Gate follows the modulation, inverted by the polarity bit
    for (k = 0; k < 4; k++) begin
      nfcmc_host_inst.wr(nfcmc_pkg::ADDR_LM_CFG, {5'h0, k[1], 1'b1, k[0]});
      mod_signal <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      c1(external_modulation_gate, !k[1]);
      mod_signal <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      c1(external_modulation_gate, k[1]);
    end
    // Driver load modulation: idle code 0, modulated code 4
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_LM_IMP, 8'h40);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_LM_CFG, 8'h01);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_OP_CTRL, 8'h88);
    #1;
    c8(drv_segments, 8'hff);
    tx_bit <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    c8(drv_segments, 8'h0f);
    tx_bit <= 1'b0;
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_OP_CTRL, 8'h00);
    nfcmc_host_inst.wr(nfcmc_pkg::ADDR_OP_CTRL, 8'h04);
    #1;
    c1(rc_osc_enable & !osc_enable, 1'b1);
    wait_for(1, 1100);
    nfcmc_host_inst.rd(nfcmc_pkg::ADDR_STATUS, d);
    c8(d, 8'h02);
    c1(irq, 1'b0);
    wake_differs <= 1'b1;
    @(posedge core_clk);
    wake_differs <= 1'b0;
    wait_for(0, 5);
    complete_run();
  end
endmodule // nfcmc_top_tb
